// >>> anc_regs.svh
`ifndef ANC_REGS_SVH
`define ANC_REGS_SVH
// Register map
`define ANC_ADDR_W 8
`define ANC_DATA_W 8
`define ANC_MISC_CONTROL_B_ADDR 8'h35
`define ANC_BENCH_OVERRIDE_ADDR 8'h3D
// Reset values and writable masks
`define ANC_MISC_RESET 8'h80
`define ANC_BENCH_RESET 8'h00
`define ANC_MISC_MASK 8'h8F
`define ANC_BENCH_MASK 8'h1F
`define ANC_ZERO_BYTE 8'h00
// misc_control_b fields
`define ANC_MISC_TEST_BIT 7
`define ANC_MISC_DISCHARGE_DIS 3
`define ANC_MISC_HPH_DELAY 2
`define ANC_MISC_HPH_CONFIG 1
`define ANC_MISC_PWRDN_EN 0
// bench_override fields
`define ANC_BENCH_LINE_MUTE 4
`define ANC_BENCH_MONITOR 3
`define ANC_BENCH_PLAYBACK 2
`define ANC_BENCH_MIC_R_MUTE 1
`define ANC_BENCH_MIC_L_MUTE 0
// Headphone selection and startup delay
`define ANC_HPH_SEL_W 2
`define ANC_HPH_SEL_RESET 2'h0
`define ANC_CLOCK_PERIOD_NS 10
`define ANC_HPH_DELAY_NS 1000000
// Pin synchroniser lanes
`define ANC_PIN_MODE_MID 0
`define ANC_PIN_NOISE_CANCEL 1
`define ANC_PIN_COUNT 2
`define ANC_PIN_RESET 2'h2
`endif

// >>> anc_pkg.sv
`default_nettype none
`include "anc_regs.svh"
package anc_pkg;

   typedef enum logic [0:0] {
      ANC_HPH_APPLIED = 1'b0,
      ANC_HPH_WAIT = 1'b1
   } anc_hph_state_t;

   typedef struct packed {
      logic [`ANC_DATA_W-1:0] misc;
      logic [`ANC_DATA_W-1:0] bench;
      logic [`ANC_DATA_W-1:0] rdata;
      anc_hph_state_t hph;
      logic [`ANC_HPH_SEL_W-1:0] hph_sel;
      logic hph_sel_valid;
      logic hph_mono_diff;
      logic hph_left_en;
      logic hph_right_en;
      logic supply_connected;
      logic discharge;
      logic power_down;
      logic line_mute;
      logic monitor;
      logic playback;
      logic mic_r_mute;
      logic mic_l_mute;
      logic test_bit;
   } anc_state_t;

endpackage : anc_pkg
`default_nettype wire

// >>> anc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module anc_pin_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clock,             // System clock
   input wire logic i_rst,               // Synchronous reset
   input wire logic [WIDTH-1:0] i_async, // Pin levels
   output logic [WIDTH-1:0] o_sync       // Synchronised levels
);

   typedef struct packed {
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage1;
   } anc_sync_st_t;

   anc_sync_st_t sync_ff;
   anc_sync_st_t nxt_sync;

   // Stage one feeds stage two only
   always_comb
   begin
      nxt_sync.stage1 = i_async;
      nxt_sync.stage2 = sync_ff.stage1;
      if (i_rst)
      begin
         nxt_sync.stage1 = RESET_VAL;
         nxt_sync.stage2 = RESET_VAL;
      end
   end

   always_ff @(posedge i_clock)
   begin
      sync_ff <= nxt_sync;
   end

   assign o_sync = sync_ff.stage2;

endmodule : anc_pin_sync
`default_nettype wire

// >>> anc_startup_delay.sv
`timescale 1ns/1ps
`default_nettype none
module anc_startup_delay #(
   parameter int DELAY_CYCLES = 100000
) (
   input wire logic i_clock, // System clock
   input wire logic i_rst,   // Synchronous reset
   input wire logic i_start, // Start pulse
   output logic o_busy,      // Delay running
   output logic o_done       // One-cycle end pulse
);

   localparam int CW = $clog2(DELAY_CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(DELAY_CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic busy;
      logic done;
   } anc_dly_st_t;

   anc_dly_st_t dly_ff;
   anc_dly_st_t nxt_dly;

   always_comb
   begin
      nxt_dly = dly_ff;
      nxt_dly.done = 1'b0;
      if (i_start)
      begin
         nxt_dly.busy = 1'b1;
         nxt_dly.count = LOAD;
      end
      else if (dly_ff.busy)
      begin
         if (dly_ff.count == '0)
         begin
            nxt_dly.busy = 1'b0;
            nxt_dly.done = 1'b1;
         end
         else
         begin
            nxt_dly.count = dly_ff.count - CW'(1);
         end
      end
      if (i_rst)
      begin
         nxt_dly = '0;
      end
   end

   always_ff @(posedge i_clock)
   begin
      dly_ff <= nxt_dly;
   end

   assign o_busy = dly_ff.busy;
   assign o_done = dly_ff.done;

endmodule : anc_startup_delay
`default_nettype wire

// >>> anc_driver_mode_override_regs.sv
// Functional notes
// (RULE_01) Misc bit 7 is a test bit resetting to one; software must not write it.
// (RULE_02) Misc bit 3 one disables mic supply discharge while supply is off.
// (RULE_03) Misc bit 2 one postpones applying headphone selection at startup.
// (RULE_04) Misc bit 1 picks stereo single-ended (0) or mono differential (1).
// (RULE_05) Mono differential uses the right audio path as amplifier input.
// (RULE_06) Misc bit 0 one allows power-down through the keep-alive bit.
// (RULE_07) Override bit 4 mutes the line input in every mode.
// (RULE_08) Override bit 3 forces monitor mode like the mid-level mode pin.
// (RULE_09) Override bit 2 forces playback-only like a low noise-cancel pin.
// (RULE_10) Override bit 1 is the right-named mic master mute, any mode.
// (RULE_11) Override bit 0 is the left mic master mute, any mode.
// (RULE_12) Supply disconnect control cuts the mic supply pin and starts discharge.
// (RULE_13) Undescribed bits read as zero and ignore writes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "anc_regs.svh"
module anc_driver_mode_override_regs #(
   parameter int HPH_DELAY_CYCLES = `ANC_HPH_DELAY_NS / `ANC_CLOCK_PERIOD_NS
) (
   input wire logic i_clock,                          // 100 MHz clock
   input wire logic i_rst,                            // Sync reset, high
   input wire logic [`ANC_ADDR_W-1:0] i_addr,         // Register address
   input wire logic [`ANC_DATA_W-1:0] i_wdata,        // Write data
   input wire logic i_wr,                             // Write strobe
   input wire logic i_rd,                             // Read strobe
   output logic [`ANC_DATA_W-1:0] o_rdata,            // Read data, next cycle
   input wire logic i_mode_pin_mid,                   // Mode pin at mid level
   input wire logic i_noise_cancel_pin,               // Noise-cancel pin level
   input wire logic i_mic_supply_disconnect,          // Supply-off control bit
   input wire logic i_power_keep_alive,               // Keep-alive control bit
   input wire logic i_startup,                        // Startup pulse
   input wire logic [`ANC_HPH_SEL_W-1:0] i_headphone_input_select, // Stored select
   input wire logic i_line_mute_req,                  // Other line mute
   input wire logic i_mic_r_mute_req,                 // Other right mic mute
   input wire logic i_mic_l_mute_req,                 // Other left mic mute
   output logic [`ANC_HPH_SEL_W-1:0] o_headphone_input_select, // Applied select
   output logic o_headphone_select_valid,             // Select applied
   output logic o_headphone_output_config,            // 1 mono differential
   output logic o_hph_left_input_en,                  // Left path to amp
   output logic o_hph_right_input_en,                 // Right path to amp
   output logic o_mic_supply_connected,               // Supply pin connected
   output logic o_mic_supply_discharge,               // Discharge active
   output logic o_power_down,                         // Power-down request
   output logic o_line_mute,                          // Line input muted
   output logic o_monitor_mode,                       // Monitor mode active
   output logic o_playback_only,                      // Playback-only active
   output logic o_mic_r_mute,                         // Right mic muted
   output logic o_mic_l_mute,                         // Left mic muted
   output logic o_test_bit                            // Factory test bit
);
   import anc_pkg::*;

   anc_state_t st_ff;
   anc_state_t nxt_st;
   logic [`ANC_PIN_COUNT-1:0] pins_sync;
   logic dly_start;
   logic dly_busy;
   logic dly_done;

   // Unmapped or reserved bits answer zero
   function automatic logic [`ANC_DATA_W-1:0] read_word(
      input logic [`ANC_ADDR_W-1:0] addr,
      input logic [`ANC_DATA_W-1:0] misc,
      input logic [`ANC_DATA_W-1:0] bench
   );
      logic [`ANC_DATA_W-1:0] word;
      word = `ANC_ZERO_BYTE;
      case (addr)
         `ANC_MISC_CONTROL_B_ADDR: word = misc & `ANC_MISC_MASK;   // see (RULE_13)
         `ANC_BENCH_OVERRIDE_ADDR: word = bench & `ANC_BENCH_MASK; // see (RULE_13)
         default: word = `ANC_ZERO_BYTE;
      endcase
      return word;
   endfunction : read_word

   // Pins come from the analog side, so two flops before use
   anc_pin_sync #(
      .WIDTH(`ANC_PIN_COUNT),
      .RESET_VAL(`ANC_PIN_RESET)
   ) u_pin_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_noise_cancel_pin, i_mode_pin_mid}),
      .o_sync(pins_sync)
   );

   // A startup during a running delay is ignored
   assign dly_start = i_startup && st_ff.misc[`ANC_MISC_HPH_DELAY] &&
                      (st_ff.hph == ANC_HPH_APPLIED); // see (RULE_03)

   anc_startup_delay #(
      .DELAY_CYCLES(HPH_DELAY_CYCLES)
   ) u_startup_delay (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_start(dly_start),
      .o_busy(dly_busy),
      .o_done(dly_done)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = `ANC_ZERO_BYTE;

      // Register writes; test bit stays writable for factory use
      if (i_wr)
      begin
         if (i_addr == `ANC_MISC_CONTROL_B_ADDR)
         begin
            nxt_st.misc = i_wdata & `ANC_MISC_MASK; // see (RULE_01) see (RULE_13)
         end
         if (i_addr == `ANC_BENCH_OVERRIDE_ADDR)
         begin
            nxt_st.bench = i_wdata & `ANC_BENCH_MASK; // see (RULE_13)
         end
      end
      if (i_rd)
      begin
         nxt_st.rdata = read_word(i_addr, st_ff.misc, st_ff.bench);
      end

      // Headphone selection sequencing
      unique case (st_ff.hph)
         ANC_HPH_APPLIED:
         begin
            if (dly_start)
            begin
               nxt_st.hph = ANC_HPH_WAIT; // see (RULE_03)
               nxt_st.hph_sel_valid = 1'b0;
            end
            else
            begin
               nxt_st.hph_sel = i_headphone_input_select;
               nxt_st.hph_sel_valid = 1'b1;
            end
         end
         ANC_HPH_WAIT:
         begin
            // Old select held to avoid pops while caps charge
            if (dly_done)
            begin
               nxt_st.hph = ANC_HPH_APPLIED; // see (RULE_03)
               nxt_st.hph_sel = i_headphone_input_select;
               nxt_st.hph_sel_valid = 1'b1;
            end
         end
      endcase

      // Headphone output configuration
      nxt_st.hph_mono_diff = st_ff.misc[`ANC_MISC_HPH_CONFIG]; // see (RULE_04)
      nxt_st.hph_left_en = !st_ff.misc[`ANC_MISC_HPH_CONFIG]; // see (RULE_05)
      nxt_st.hph_right_en = 1'b1; // see (RULE_05)

      // Mic supply switch and discharge
      nxt_st.supply_connected = !i_mic_supply_disconnect; // see (RULE_12)
      nxt_st.discharge = i_mic_supply_disconnect &&
                         !st_ff.misc[`ANC_MISC_DISCHARGE_DIS]; // see (RULE_02) see (RULE_12)

      // Power-down only when enabled and keep-alive dropped
      nxt_st.power_down = st_ff.misc[`ANC_MISC_PWRDN_EN] &&
                          !i_power_keep_alive; // see (RULE_06)

      // Master overrides win over every other source
      nxt_st.line_mute = st_ff.bench[`ANC_BENCH_LINE_MUTE] || i_line_mute_req; // see (RULE_07)
      nxt_st.monitor = st_ff.bench[`ANC_BENCH_MONITOR] ||
                       pins_sync[`ANC_PIN_MODE_MID]; // see (RULE_08)
      nxt_st.playback = st_ff.bench[`ANC_BENCH_PLAYBACK] ||
                        !pins_sync[`ANC_PIN_NOISE_CANCEL]; // see (RULE_09)
      nxt_st.mic_r_mute = st_ff.bench[`ANC_BENCH_MIC_R_MUTE] || i_mic_r_mute_req; // see (RULE_10)
      nxt_st.mic_l_mute = st_ff.bench[`ANC_BENCH_MIC_L_MUTE] || i_mic_l_mute_req; // see (RULE_11)
      nxt_st.test_bit = st_ff.misc[`ANC_MISC_TEST_BIT]; // see (RULE_01)

      if (i_rst)
      begin
         nxt_st = '0;
         nxt_st.misc = `ANC_MISC_RESET; // see (RULE_01)
         nxt_st.bench = `ANC_BENCH_RESET;
         nxt_st.hph = ANC_HPH_APPLIED;
         nxt_st.hph_sel = `ANC_HPH_SEL_RESET;
         nxt_st.hph_left_en = 1'b1;
         nxt_st.hph_right_en = 1'b1;
         nxt_st.supply_connected = 1'b1;
      end
   end

   always_ff @(posedge i_clock)
   begin
      st_ff <= nxt_st;
   end

   assign o_rdata = st_ff.rdata;
   assign o_headphone_input_select = st_ff.hph_sel;
   assign o_headphone_select_valid = st_ff.hph_sel_valid;
   assign o_headphone_output_config = st_ff.hph_mono_diff;
   assign o_hph_left_input_en = st_ff.hph_left_en;
   assign o_hph_right_input_en = st_ff.hph_right_en;
   assign o_mic_supply_connected = st_ff.supply_connected;
   assign o_mic_supply_discharge = st_ff.discharge;
   assign o_power_down = st_ff.power_down;
   assign o_line_mute = st_ff.line_mute;
   assign o_monitor_mode = st_ff.monitor;
   assign o_playback_only = st_ff.playback;
   assign o_mic_r_mute = st_ff.mic_r_mute;
   assign o_mic_l_mute = st_ff.mic_l_mute;
   assign o_test_bit = st_ff.test_bit;

   // Checks on the design's own behaviour
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   property p_test_reset;
      $past(i_rst) |-> st_ff.misc[`ANC_MISC_TEST_BIT] ##1 o_test_bit;
   endproperty
   a_test_reset: assert property (p_test_reset) // see (RULE_01)
      else $error("test bit not one after reset");

   property p_discharge;
      (i_mic_supply_disconnect && !st_ff.misc[`ANC_MISC_DISCHARGE_DIS])
         |=> o_mic_supply_discharge;
   endproperty
   a_discharge: assert property (p_discharge) // see (RULE_02)
      else $error("discharge missing while supply off");

   property p_no_discharge;
      (!i_mic_supply_disconnect || st_ff.misc[`ANC_MISC_DISCHARGE_DIS])
         |=> !o_mic_supply_discharge;
   endproperty
   a_no_discharge: assert property (p_no_discharge) // see (RULE_12)
      else $error("discharge active when it should not be");

   property p_disconnect;
      i_mic_supply_disconnect |=> !o_mic_supply_connected;
   endproperty
   a_disconnect: assert property (p_disconnect) // see (RULE_12)
      else $error("mic supply still connected");

   property p_hph_delay;
      dly_start |=> !o_headphone_select_valid ##1 !o_headphone_select_valid;
   endproperty
   a_hph_delay: assert property (p_hph_delay) // see (RULE_03)
      else $error("headphone select applied without delay");

   property p_hph_nodelay;
      (i_startup && !st_ff.misc[`ANC_MISC_HPH_DELAY] &&
       st_ff.hph == ANC_HPH_APPLIED) |=> o_headphone_select_valid;
   endproperty
   a_hph_nodelay: assert property (p_hph_nodelay) // see (RULE_03)
      else $error("headphone select delayed while delay off");

   // Waiting without a running counter would hang the selection forever
   property p_dly_busy;
      (st_ff.hph == ANC_HPH_WAIT) |-> (dly_busy || dly_done);
   endproperty
   a_dly_busy: assert property (p_dly_busy) // see (RULE_03)
      else $error("wait state without running delay");

   property p_mono;
      st_ff.misc[`ANC_MISC_HPH_CONFIG] |=>
         o_headphone_output_config && !o_hph_left_input_en && o_hph_right_input_en;
   endproperty
   a_mono: assert property (p_mono) // see (RULE_05)
      else $error("mono differential routing wrong");

   property p_stereo;
      !st_ff.misc[`ANC_MISC_HPH_CONFIG] |=>
         !o_headphone_output_config && o_hph_left_input_en;
   endproperty
   a_stereo: assert property (p_stereo) // see (RULE_04)
      else $error("stereo single-ended routing wrong");

   property p_power_down;
      !st_ff.misc[`ANC_MISC_PWRDN_EN] |=> !o_power_down;
   endproperty
   a_power_down: assert property (p_power_down) // see (RULE_06)
      else $error("power-down while path disabled");

   property p_line_mute;
      st_ff.bench[`ANC_BENCH_LINE_MUTE] |=> o_line_mute;
   endproperty
   a_line_mute: assert property (p_line_mute) // see (RULE_07)
      else $error("line master mute ignored");

   property p_monitor;
      st_ff.bench[`ANC_BENCH_MONITOR] |=> o_monitor_mode;
   endproperty
   a_monitor: assert property (p_monitor) // see (RULE_08)
      else $error("monitor force ignored");

   property p_playback;
      st_ff.bench[`ANC_BENCH_PLAYBACK] |=> o_playback_only;
   endproperty
   a_playback: assert property (p_playback) // see (RULE_09)
      else $error("playback force ignored");

   property p_mic_r;
      st_ff.bench[`ANC_BENCH_MIC_R_MUTE] |=> o_mic_r_mute;
   endproperty
   a_mic_r: assert property (p_mic_r) // see (RULE_10)
      else $error("right mic master mute ignored");

   property p_mic_l;
      st_ff.bench[`ANC_BENCH_MIC_L_MUTE] |=> o_mic_l_mute;
   endproperty
   a_mic_l: assert property (p_mic_l) // see (RULE_11)
      else $error("left mic master mute ignored");

   property p_reserved;
      (i_wr && i_addr == `ANC_BENCH_OVERRIDE_ADDR) ##1 !i_wr ##1
      (i_rd && !i_wr && i_addr == `ANC_BENCH_OVERRIDE_ADDR)
         |=> o_rdata == ($past(i_wdata, 3) & `ANC_BENCH_MASK);
   endproperty
   a_reserved: assert property (p_reserved) // see (RULE_13)
      else $error("override read-back wrong");

   property p_unmapped;
      (i_rd && i_addr != `ANC_MISC_CONTROL_B_ADDR &&
       i_addr != `ANC_BENCH_OVERRIDE_ADDR) |=> o_rdata == `ANC_ZERO_BYTE;
   endproperty
   a_unmapped: assert property (p_unmapped) // see (RULE_13)
      else $error("unmapped read not zero");

   property p_cov_delay;
      dly_start ##[1:1000] dly_done;
   endproperty
   c_cov_delay: cover property (p_cov_delay);

   property p_cov_mono;
      $rose(o_headphone_output_config);
   endproperty
   c_cov_mono: cover property (p_cov_mono);

   property p_cov_discharge;
      $rose(o_mic_supply_discharge);
   endproperty
   c_cov_discharge: cover property (p_cov_discharge);

   property p_cov_playback_pin;
      !pins_sync[`ANC_PIN_NOISE_CANCEL] && !st_ff.bench[`ANC_BENCH_PLAYBACK] ##1 o_playback_only;
   endproperty
   c_cov_playback_pin: cover property (p_cov_playback_pin);

endmodule : anc_driver_mode_override_regs
`default_nettype wire

// >>> anc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "anc_regs.svh"
module anc_host_model (
   input wire logic i_clock,                   // Bus clock
   input wire logic [`ANC_DATA_W-1:0] i_rdata, // Read data from device
   output logic [`ANC_ADDR_W-1:0] o_addr,      // Register address
   output logic [`ANC_DATA_W-1:0] o_wdata,     // Write data
   output logic o_wr,                          // Write strobe
   output logic o_rd                           // Read strobe
);
   initial
   begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'h0;
      o_rd = 1'h0;
   end

   // Idle bus shows the inverse of the last value so stale data never looks valid
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] val;
      val = data;
      if (addr == `ANC_MISC_CONTROL_B_ADDR)
         val[`ANC_MISC_TEST_BIT] = 1'h1;
      @(posedge i_clock);
      o_addr <= addr;
      o_wdata <= val;
      o_wr <= 1'h1;
      @(posedge i_clock);
      o_wr <= 1'h0;
      o_addr <= ~addr;
      o_wdata <= ~val;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge i_clock);
      o_addr <= addr;
      o_rd <= 1'h1;
      @(posedge i_clock);
      o_rd <= 1'h0;
      o_addr <= ~addr;
      #1;
      data = i_rdata;
   endtask : read_reg
endmodule : anc_host_model
`default_nettype wire

// >>> tb_anc_driver_mode_override_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "anc_regs.svh"
module tb_anc_driver_mode_override_regs;
   localparam int DLY = 4;
   logic clk, rst, wr, rd, pin_mid, pin_nc, disc, keep, start, lmr, rmr, mlr;
   logic [7:0] addr, wdata, rdata, rv;
   logic [1:0] sel_in, sel_out;
   logic sel_valid, hcfg, len, ren, conn, dis, pdn, lmute, mon, pbo, mr, ml, tbit;
   int bad_count;
   int compares;
   int n;

   anc_host_model host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd));

   anc_driver_mode_override_regs #(.HPH_DELAY_CYCLES(DLY)) uut (.i_clock(clk), .i_rst(rst),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_mode_pin_mid(pin_mid), .i_noise_cancel_pin(pin_nc), .i_mic_supply_disconnect(disc),
      .i_power_keep_alive(keep), .i_startup(start), .i_headphone_input_select(sel_in),
      .i_line_mute_req(lmr), .i_mic_r_mute_req(rmr), .i_mic_l_mute_req(mlr),
      .o_headphone_input_select(sel_out), .o_headphone_select_valid(sel_valid),
      .o_headphone_output_config(hcfg), .o_hph_left_input_en(len),
      .o_hph_right_input_en(ren), .o_mic_supply_connected(conn),
      .o_mic_supply_discharge(dis), .o_power_down(pdn), .o_line_mute(lmute),
      .o_monitor_mode(mon), .o_playback_only(pbo), .o_mic_r_mute(mr), .o_mic_l_mute(ml),
      .o_test_bit(tbit));

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check8

   task automatic check1(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask : check1

   task automatic settle(input int cycles);
      repeat (cycles) @(posedge clk);
      #1;
   endtask : settle

   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic test_reset;
      host.read_reg(`ANC_MISC_CONTROL_B_ADDR, rv);
      check8("misc reset", 8'h80, rv);
      host.read_reg(`ANC_BENCH_OVERRIDE_ADDR, rv);
      check8("bench reset", 8'h00, rv);
      check1("test_bit", 1'h1, tbit);
      check1("hph_config", 1'h0, hcfg);
      check1("supply_conn", 1'h1, conn);
      check1("power_down", 1'h0, pdn);
      $display("test reset done");
   endtask : test_reset

   task automatic test_reserved;
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'hFF);
      host.read_reg(`ANC_MISC_CONTROL_B_ADDR, rv);
      check8("misc reserved", 8'h8F, rv);
      host.write_reg(`ANC_BENCH_OVERRIDE_ADDR, 8'hFF);
      host.read_reg(`ANC_BENCH_OVERRIDE_ADDR, rv);
      check8("bench reserved", 8'h1F, rv);
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h00);
      host.write_reg(`ANC_BENCH_OVERRIDE_ADDR, 8'h00);
      host.write_reg(8'h36, 8'h5A);
      host.read_reg(8'h36, rv);
      check8("unmapped", 8'h00, rv);
      host.read_reg(`ANC_MISC_CONTROL_B_ADDR, rv);
      check8("misc after", 8'h80, rv);
      $display("test reserved done");
   endtask : test_reserved

   task automatic test_bench;
      logic [4:0] e;
      for (int i = 0; i < 5; i++)
      begin
         e = 5'h01 << i;
         host.write_reg(`ANC_BENCH_OVERRIDE_ADDR, {3'h0, e});
         settle(1);
         check1("line_mute", e[4], lmute);
         check1("monitor", e[3], mon);
         check1("playback", e[2], pbo);
         check1("mic_r_mute", e[1], mr);
         check1("mic_l_mute", e[0], ml);
      end
      host.write_reg(`ANC_BENCH_OVERRIDE_ADDR, 8'h00);
      pin_mid <= 1'h1;
      pin_nc <= 1'h0;
      lmr <= 1'h1;
      rmr <= 1'h1;
      mlr <= 1'h1;
      settle(3);
      check1("monitor pin", 1'h1, mon);
      check1("playback pin", 1'h1, pbo);
      check1("line req", 1'h1, lmute);
      check1("mic_r req", 1'h1, mr);
      check1("mic_l req", 1'h1, ml);
      @(posedge clk);
      pin_mid <= 1'h0;
      pin_nc <= 1'h1;
      lmr <= 1'h0;
      rmr <= 1'h0;
      mlr <= 1'h0;
      settle(3);
      check1("monitor off", 1'h0, mon);
      check1("playback off", 1'h0, pbo);
      check1("line req off", 1'h0, lmute);
      check1("mic_r off", 1'h0, mr);
      check1("mic_l off", 1'h0, ml);
      $display("test bench done");
   endtask : test_bench

   task automatic test_misc;
      @(posedge clk);
      disc <= 1'h1;
      settle(1);
      check1("supply_conn", 1'h0, conn);
      check1("discharge", 1'h1, dis);
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h08);
      settle(1);
      check1("discharge off", 1'h0, dis);
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h01);
      settle(1);
      check1("discharge on", 1'h1, dis);
      check1("pdn held", 1'h0, pdn);
      @(posedge clk);
      disc <= 1'h0;
      keep <= 1'h0;
      settle(1);
      check1("pdn", 1'h1, pdn);
      check1("supply back", 1'h1, conn);
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h02);
      settle(1);
      check1("pdn disabled", 1'h0, pdn);
      check1("hph mono", 1'h1, hcfg);
      check1("left en", 1'h0, len);
      check1("right en", 1'h1, ren);
      @(posedge clk);
      keep <= 1'h1;
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h00);
      settle(1);
      check1("hph stereo", 1'h0, hcfg);
      check1("left back", 1'h1, len);
      $display("test misc done");
   endtask : test_misc

   task automatic test_startup;
      @(posedge clk);
      sel_in <= 2'h2;
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      settle(1);
      check1("valid no delay", 1'h1, sel_valid);
      check8("sel no delay", 8'h02, {6'h00, sel_out});
      host.write_reg(`ANC_MISC_CONTROL_B_ADDR, 8'h04);
      @(posedge clk);
      start <= 1'h1;
      @(posedge clk);
      start <= 1'h0;
      sel_in <= 2'h3;
      settle(1);
      check1("valid drop", 1'h0, sel_valid);
      for (n = 2; n < 40; n++)
      begin
         settle(1);
         if (n == 3)
            check8("sel held", 8'h02, {6'h00, sel_out});
         if (sel_valid === 1'h1)
            break;
      end
      if (n == 40)
      begin
         bad_count++;
         $display("[ERR] startup wait expected %0d seen timeout", DLY + 1);
      end
      // Count loads DLY-1, done one edge after zero, valid one edge later
      check8("wait cycles", 8'(DLY + 1), 8'(n));
      check8("sel latched", 8'h03, {6'h00, sel_out});
      $display("test startup done");
   endtask : test_startup

   initial
   begin
      bad_count = 0;
      compares = 0;
      rst = 1'h1;
      pin_mid = 1'h0;
      pin_nc = 1'h1;
      disc = 1'h0;
      keep = 1'h1;
      start = 1'h0;
      lmr = 1'h0;
      rmr = 1'h0;
      mlr = 1'h0;
      sel_in = 2'h0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      test_reset();
      test_reserved();
      test_bench();
      test_misc();
      test_startup();
      finish_test();
   end
endmodule : tb_anc_driver_mode_override_regs
`default_nettype wire
